//--- i2c_register_slave_port.v
// Contract
// - sda falling while scl high is a start
// - sda rising while scl high is a stop; bus released
// - repeated start keeps context and expects a new address byte
// - stop aborts frame at any bit, except in start's own high phase
// - device drives sda low through whole ninth clock after good write byte
// - write frame: start, address with dir 0, pointer, data bytes, stop
// - device acks own address with write direction
// - second write byte loads pointer and is acked
// - third and later write bytes stored at pointer and acked
// - device acks own address with read direction
// - start then read address resets pointer to 0x00
// - read bits valid on scl rising edge
// - stop allowed after any read byte; pointer advances per byte
// - pointer preset by write address and pointer, then repeated start read
// - pointer saturates at 0xff for further reads
// - bytes are eight bits msb first plus one ack clock
// - sda changes only while scl low
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_defines.vh"

module i2c_register_slave_port #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire clk,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg [7:0] reg_addr,
  output reg [7:0] wr_data,
  output reg wr_strobe,
  input wire [7:0] rd_data,
  output reg rd_strobe,
  output reg busy
);

  // ****************************************
  // input synchronisers and glitch filters
  // ****************************************
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [`FILTER_LEN-1:0] scl_hist;
  reg [`FILTER_LEN-1:0] sda_hist;
  reg scl_f;
  reg sda_f;
  reg scl_d;
  reg sda_d;

  always @(posedge clk) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hist <= {`FILTER_LEN{1'b1}};
      sda_hist <= {`FILTER_LEN{1'b1}};
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_hist <= {scl_hist[`FILTER_LEN-2:0], scl_sync[1]};
      sda_hist <= {sda_hist[`FILTER_LEN-2:0], sda_sync[1]};
      if (&scl_hist) scl_f <= 1'b1;
      else if (~|scl_hist) scl_f <= 1'b0;
      if (&sda_hist) sda_f <= 1'b1;
      else if (~|sda_hist) sda_f <= 1'b0;
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_det = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_det = scl_f & scl_d & ~sda_d & sda_f;

  // ****************************************
  // frame state machine
  // ****************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_PTR = 6'h04;
  localparam [5:0] ST_WDATA = 6'h08;
  localparam [5:0] ST_RDATA = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;

  reg [5:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg in_ack;
  reg ack_drive;
  reg start_high;
  reg [7:0] tx;
  reg busy_wr;

  always @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      in_ack <= 1'b0;
      ack_drive <= 1'b0;
      start_high <= 1'b0;
      tx <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      reg_addr <= `PTR_RESET;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      busy <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      sda_out <= 1'b0;
      if (scl_fall) start_high <= 1'b0;
      if (start_det) begin
        // a start or repeated start always re-arms address reception
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        ack_drive <= 1'b0;
        sda_oe <= 1'b0;
        start_high <= 1'b1;
        busy <= 1'b1;
      end else if (stop_det && !start_high) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        ack_drive <= 1'b0;
        sda_oe <= 1'b0;
        busy <= 1'b0;
      end else if (scl_rise && !in_ack && state != ST_IDLE && state != ST_IGNORE) begin
        shift <= {shift[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && in_ack && state == ST_RDATA && !ack_drive) begin
        // master answer on ninth clock: low continues, high ends sending
        if (sda_f) state <= ST_IGNORE;
      end else if (scl_fall) begin
        if (in_ack) begin
          // ninth clock over: release, then prepare next byte
          in_ack <= 1'b0;
          ack_drive <= 1'b0;
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
          if (state == ST_RDATA) begin
            tx <= {rd_data[6:0], 1'b0};
            sda_oe <= ~rd_data[7];
            rd_strobe <= 1'b1;
            // pointer sticks at the top location
            if (reg_addr != `PTR_TOP) reg_addr <= reg_addr + 8'h01;
          end
        end else if (state == ST_RDATA && bit_cnt != `BITS_PER_BYTE) begin
          sda_oe <= ~tx[7];
          tx <= {tx[6:0], 1'b0};
        end else if (bit_cnt == `BITS_PER_BYTE) begin
          in_ack <= 1'b1;
          case (state)
            ST_ADDR: begin
              if (shift[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                ack_drive <= 1'b1;
                if (shift[0] == `DIR_READ) begin
                  state <= ST_RDATA;
                  // fresh start straight to read resets; after repeated start keep preset
                  if (!busy_wr) reg_addr <= `PTR_RESET;
                end else begin
                  state <= ST_PTR;
                end
              end else begin
                state <= ST_IGNORE;
                in_ack <= 1'b0;
              end
            end
            ST_PTR: begin
              reg_addr <= shift;
              sda_oe <= 1'b1;
              ack_drive <= 1'b1;
              state <= ST_WDATA;
            end
            ST_WDATA: begin
              wr_data <= shift;
              wr_strobe <= 1'b1;
              sda_oe <= 1'b1;
              ack_drive <= 1'b1;
            end
            ST_RDATA: begin
              sda_oe <= 1'b0;
            end
            default: begin
              sda_oe <= 1'b0;
            end
          endcase
        end
      end
      if (state == ST_RDATA && in_ack && ack_drive && scl_fall) begin
        tx <= {rd_data[6:0], 1'b0};
        sda_oe <= ~rd_data[7];
        rd_strobe <= 1'b1;
      end
    end
  end

  // remembers that the current frame had a write address plus pointer
  always @(posedge clk) begin
    if (!rstn) begin
      busy_wr <= 1'b0;
    end else if (stop_det && !start_high) begin
      busy_wr <= 1'b0;
    end else if (state == ST_PTR && scl_fall && bit_cnt == `BITS_PER_BYTE && !in_ack) begin
      busy_wr <= 1'b1;
    end else if (state == ST_ADDR && start_det == 1'b0 && bit_cnt == 4'h0 && !busy) begin
      busy_wr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- i2c_slave_defines.vh
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH

// 7-bit device address with the strap pin tied low
`define DEV_ADDR_DEFAULT 7'h4a
`define PTR_RESET 8'h00
`define PTR_TOP 8'hff
`define RESERVED_LO 8'hf6
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT 4'h9
`define FILTER_LEN 3

`endif

//--- slave_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module slave_port_checker(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] reg_addr,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic busy
);
  // ****
  // port checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_oe_pulls_low: assert property (sda_oe |-> !sda_out) else $error("sda high");
  chk_wr_one_cycle: assert property (wr_strobe |=> !wr_strobe) else $error("wr long");
  chk_rd_one_cycle: assert property (rd_strobe |=> !rd_strobe) else $error("rd long");
  chk_wr_in_frame: assert property (wr_strobe |-> busy) else $error("wr idle");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("oe moved");
  chk_idle_free: assert property (!busy |-> !sda_oe) else $error("idle drive");
  chk_start_sets_busy: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:12] busy)
    else $error("no start");
  chk_stop_ends_busy: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:12] !busy)
    else $error("no stop");
  chk_reset_clears: assert property (disable iff (1'b0) !rstn |=> !busy && !sda_oe && reg_addr == 8'h00)
    else $error("reset");
  cov_write: cover property (wr_strobe);
  cov_read: cover property (rd_strobe);
  cov_ack: cover property ($rose(sda_oe));
endmodule
bind i2c_register_slave_port slave_port_checker slave_port_checker_i(.clk, .rstn, .scl_in, .sda_in,
  .sda_out, .sda_oe, .reg_addr, .wr_strobe, .rd_strobe, .busy);
`default_nettype wire

//--- bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module bus_master(
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  // ****
  // bus sequences, 125 ns per bit
  // ****
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start();
    #40 sda = 1'b1;
    #22.5 scl = 1'b1;
    #31.25 sda = 1'b0;
    #31.25 scl = 1'b0;
  endtask
  task automatic stop();
    #40 sda = 1'b0;
    #22.5 scl = 1'b1;
    #31.25 sda = 1'b1;
  endtask
  // nine clocks: eight bits then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #40 sda = tx[i];
      #22.5 scl = 1'b1;
      rx[i] = sda_line;
      #62.5 scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl_in = 1'b1;
  logic sda_in = 1'b1;
  logic [7:0] rd_data = 8'h00;
  wire logic sda_out, sda_oe, wr_strobe, rd_strobe, busy, m_scl, m_sda;
  wire logic [7:0] reg_addr, wr_data;
  logic [7:0] ca, cd;
  logic [8:0] rx;
  logic [15:0] rows [3] = '{16'h0310, 16'hf5a7, 16'h7f00};
  int n_fail = 0;
  int n_checks = 0;
  int nw = 0;
  int nr = 0;
  always #2 clk = ~clk;
  always @(negedge clk) begin
    scl_in <= m_scl;
    sda_in <= m_sda & ~sda_oe;
    rd_data <= reg_addr ^ 8'h5a;
  end
  always @(posedge clk) if (wr_strobe) begin
    ca <= reg_addr;
    cd <= wr_data;
    nw++;
  end
  always @(posedge clk) if (rd_strobe) nr++;
  i2c_register_slave_port i2c_register_slave_port_i(.clk, .rstn, .scl_in, .sda_in, .sda_out, .sda_oe,
    .reg_addr, .wr_data, .wr_strobe, .rd_data, .rd_strobe, .busy);
  bus_master bus_master_i(.scl(m_scl), .sda(m_sda), .sda_line(sda_in));
  // ****
  // helpers
  // ****
  task chk(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input logic [7:0] b, input logic acked);
    bus_master_i.xfer({b, 1'b1}, rx);
    chk({7'h00, rx[0]}, {7'h00, !acked}, "ack");
  endtask
  task rb(input logic last, input logic [7:0] exp);
    bus_master_i.xfer({8'hff, last}, rx);
    chk(rx[8:1], exp, "read byte");
  endtask
  task fin(input string t);
    bus_master_i.stop();
    #100 $display("test %s done", t);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (20) @(negedge clk);
    chk(reg_addr, 8'h00, "reset ptr");
    chk({6'h00, busy, sda_oe}, 8'h00, "reset flags");
    rstn = 1'b1;
    repeat (12) @(negedge clk);
    foreach (rows[i]) begin
      bus_master_i.start();
      wb(8'h94, 1'b1);
      wb(rows[i][15:8], 1'b1);
      wb(rows[i][7:0], 1'b1);
      fin("row write");
      chk(ca, rows[i][15:8], "wr addr");
      chk(cd, rows[i][7:0], "wr data");
      chk({7'h00, busy}, 8'h00, "busy");
      bus_master_i.start();
      wb(8'h94, 1'b1);
      wb(rows[i][15:8], 1'b1);
      bus_master_i.start();
      wb(8'h95, 1'b1);
      rb(1'b1, rows[i][15:8] ^ 8'h5a);
      fin("row read");
    end
    bus_master_i.start();
    wb(8'h94, 1'b1);
    wb(8'hfe, 1'b1);
    bus_master_i.start();
    wb(8'h95, 1'b1);
    rb(1'b0, 8'ha4);
    rb(1'b0, 8'ha5);
    rb(1'b1, 8'ha5);
    fin("saturate");
    bus_master_i.start();
    wb(8'h95, 1'b1);
    rb(1'b0, 8'h5a);
    rb(1'b1, 8'h5b);
    fin("read from zero");
    bus_master_i.start();
    wb(8'h96, 1'b0);
    wb(8'h01, 1'b0);
    fin("foreign address");
    bus_master_i.start();
    wb(8'h94, 1'b1);
    fin("early stop");
    chk(nw[7:0], 8'h03, "writes");
    chk({7'h00, busy}, 8'h00, "busy");
    bus_master_i.start();
    wb(8'h94, 1'b1);
    wb(8'h20, 1'b1);
    @(negedge clk) rstn = 1'b0;
    repeat (3) @(negedge clk);
    chk(reg_addr, 8'h00, "mid reset ptr");
    chk({6'h00, busy, sda_oe}, 8'h00, "mid reset flags");
    rstn = 1'b1;
    repeat (12) @(negedge clk);
    bus_master_i.stop();
    bus_master_i.start();
    wb(8'h95, 1'b1);
    rb(1'b1, 8'h5a);
    fin("mid reset");
    chk(nr[7:0], 8'h09, "reads");
    chk({7'h00, sda_out}, 8'h00, "sda out");
    report_and_stop();
  end
endmodule
`default_nettype wire
